// ---- core/jtg_pkg.sv ----
// Constants and types shared by the boundary-scan test port.
// Assumes a single tester drives the link pins and that TCK is the link clock.
package jtg_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int IR_W       = 4;
  localparam int DR_W       = 32;
  localparam int BSR_N      = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int TLR_HOLD   = 5;  // TMS-high cycles that always reach reset

  // ----------------------------------------------------------------------
  // Instruction codes; any other code selects the bypass path
  // ----------------------------------------------------------------------
  localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] OP_USER   = 4'h3;
  localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // ----------------------------------------------------------------------
  // Identification word fields (values arbitrary)
  // ----------------------------------------------------------------------
  localparam int ID_LSB_POS   = 0;
  localparam int ID_MAKER_POS = 1;
  localparam int ID_PART_POS  = 12;
  localparam int ID_VER_POS   = 28;
  localparam logic [3:0]  ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART    = 16'h0001;
  localparam logic [10:0] ID_MAKER   = 11'h001;
  localparam logic        ID_LSB     = 1'b1;
  localparam logic [DR_W-1:0] ID_WORD =
    (DR_W'(ID_VERSION) << ID_VER_POS) | (DR_W'(ID_PART) << ID_PART_POS) |
    (DR_W'(ID_MAKER) << ID_MAKER_POS) | (DR_W'(ID_LSB) << ID_LSB_POS);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
    ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtg_state_type;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_ID, SEL_BSR, SEL_USER
  } jtg_dr_type;

endpackage

// ---- core/jtg_tap.sv ----
// Boundary-scan test port: TAP controller, instruction and data registers,
// a user data register that streams words into the core through a FIFO.
// Assumes tck is the tester's clock, unrelated to mclk; rst is synchronous to mclk.
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// FIFO
// ------------------------------------------------------------------------
module jtg_fifo
  import jtg_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic [AW:0]      next_wptr;
  logic [AW:0]      next_rptr;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = (wptr - rptr) != (AW+1)'(DEPTH);
    out_valid = wptr != rptr;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
    out_data  = mem[rptr[AW-1:0]];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage needs no reset; only words behind the write pointer are read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------------
// Test port top
// ------------------------------------------------------------------------
module jtg_tap
  import jtg_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo,
  output logic                  tdo_oe,
  input  wire logic [BSR_N-1:0] pad_i,
  output logic      [BSR_N-1:0] pad_o,
  output logic      [BSR_N-1:0] pad_oe,
  input  wire logic [BSR_N-1:0] core_o,
  input  wire logic [BSR_N-1:0] core_oe,
  output logic                  data_valid,
  input  wire logic             data_ready,
  output logic      [DR_W-1:0]  data_out
);

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic jtg_dr_type dr_select(input logic [IR_W-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE: dr_select = SEL_BSR;
      OP_IDCODE:            dr_select = SEL_ID;
      OP_USER:              dr_select = SEL_USER;
      default:              dr_select = SEL_BYPASS;
    endcase
  endfunction

  function automatic int dr_length(input jtg_dr_type sel);
    case (sel)
      SEL_ID, SEL_USER: dr_length = DR_W;
      SEL_BSR:          dr_length = BSR_N;
      default:          dr_length = 1;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Reset into the link domain
  // ----------------------------------------------------------------------
  // The tester clock may be idle, so the link side is cleared asynchronously
  // from a registered copy of rst; its flops load constants only.
  logic link_rst;

  always_ff @(posedge mclk) begin
    link_rst <= rst;
  end

  // ----------------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------------
  jtg_state_type state;
  jtg_state_type next_state;

  always_comb begin
    case (state)
      ST_RESET:    next_state = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     next_state = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   next_state = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   next_state = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = tms ? ST_SEL_DR   : ST_IDLE;
      default:     next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge tck or posedge link_rst) begin
    if (link_rst) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction and data registers (rising TCK)
  // ----------------------------------------------------------------------
  logic [IR_W-1:0]  ir_sr;
  logic [IR_W-1:0]  ir;
  logic [DR_W-1:0]  dr_sr;
  logic [BSR_N-1:0] bsr_upd;
  logic [DR_W-1:0]  user_hold;
  logic             req_tgl;
  logic [BSR_N-1:0] pad_s1;
  logic [BSR_N-1:0] pad_s2;
  logic             ack_s1;
  logic             ack_s2;
  logic             ack_tgl;
  logic [IR_W-1:0]  next_ir_sr;
  logic [IR_W-1:0]  next_ir;
  logic [DR_W-1:0]  next_dr_sr;
  logic [BSR_N-1:0] next_bsr_upd;
  logic [DR_W-1:0]  next_user_hold;
  logic             next_req_tgl;
  logic             user_busy;
  jtg_dr_type       sel;
  int               len;

  always_comb begin
    sel            = dr_select(ir);
    len            = dr_length(sel);
    user_busy      = req_tgl != ack_s2;
    next_ir_sr     = ir_sr;
    next_ir        = ir;
    next_dr_sr     = dr_sr;
    next_bsr_upd   = bsr_upd;
    next_user_hold = user_hold;
    next_req_tgl   = req_tgl;
    case (state)
      ST_RESET: begin
        next_ir = OP_IDCODE;
      end
      ST_CAP_IR: begin
        next_ir_sr = IR_CAPTURE;
      end
      ST_SHIFT_IR: begin
        next_ir_sr = {tdi, ir_sr[IR_W-1:1]};
      end
      ST_UPD_IR: begin
        next_ir = ir_sr;
      end
      ST_CAP_DR: begin
        case (sel)
          SEL_ID:   next_dr_sr = ID_WORD;
          SEL_BSR:  next_dr_sr = DR_W'(pad_s2);
          SEL_USER: next_dr_sr = DR_W'(user_busy);
          default:  next_dr_sr = '0;
        endcase
      end
      ST_SHIFT_DR: begin
        next_dr_sr          = dr_sr >> 1;
        next_dr_sr[len - 1] = tdi;
      end
      ST_UPD_DR: begin
        if (sel == SEL_BSR) begin
          next_bsr_upd = dr_sr[BSR_N-1:0];
        end
        // A word sent while the previous one is still crossing is dropped;
        // the tester polls the busy bit captured in the same register.
        if (sel == SEL_USER && !user_busy) begin
          next_user_hold = dr_sr;
          next_req_tgl   = !req_tgl;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge tck or posedge link_rst) begin
    if (link_rst) begin
      ir_sr     <= IR_CAPTURE;
      ir        <= OP_IDCODE;
      dr_sr     <= '0;
      bsr_upd   <= '0;
      user_hold <= '0;
      req_tgl   <= 1'b0;
    end else begin
      ir_sr     <= next_ir_sr;
      ir        <= next_ir;
      dr_sr     <= next_dr_sr;
      bsr_upd   <= next_bsr_upd;
      user_hold <= next_user_hold;
      req_tgl   <= next_req_tgl;
    end
  end

  // Pin levels and the returning acknowledge cross into the TCK domain
  always_ff @(posedge tck or posedge link_rst) begin
    if (link_rst) begin
      pad_s1 <= '0;
      pad_s2 <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      pad_s1 <= pad_i;
      pad_s2 <= pad_s1;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // ----------------------------------------------------------------------
  // TDO (falling TCK)
  // ----------------------------------------------------------------------
  logic next_tdo;
  logic next_tdo_oe;

  always_comb begin
    next_tdo_oe = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
    next_tdo    = (state == ST_SHIFT_IR) ? ir_sr[0] : dr_sr[0];
  end

  always_ff @(negedge tck or posedge link_rst) begin
    if (link_rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= next_tdo;
      tdo_oe <= next_tdo_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  logic [BSR_N-1:0] core_o_q;
  logic [BSR_N-1:0] core_oe_q;
  logic             extest;

  always_ff @(posedge mclk) begin
    if (rst) begin
      core_o_q  <= '0;
      core_oe_q <= '0;
    end else begin
      core_o_q  <= core_o;
      core_oe_q <= core_oe;
    end
  end

  always_comb begin
    extest = ir == OP_EXTEST;
  end

  // Under EXTEST every pin is driven from its update cell
  genvar gi;
  generate
    for (gi = 0; gi < BSR_N; gi++) begin : g_pin
      always_comb begin
        pad_o[gi]  = extest ? bsr_upd[gi] : core_o_q[gi];
        pad_oe[gi] = extest ? 1'b1 : core_oe_q[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // User word crossing into mclk and FIFO
  // ----------------------------------------------------------------------
  // Toggle handshake: user_hold stays still until ack_tgl catches up,
  // so the word is read whole on the mclk side.
  logic next_ack_tgl;
  logic req_s1;
  logic req_s2;
  logic fifo_in_valid;
  logic fifo_in_ready;

  always_comb begin
    fifo_in_valid = req_s2 != ack_tgl;
    // A full FIFO withholds the acknowledge, which keeps the link side busy
    next_ack_tgl  = (fifo_in_valid && fifo_in_ready) ? req_s2 : ack_tgl;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      ack_tgl <= 1'b0;
    end else begin
      req_s1  <= req_tgl;
      req_s2  <= req_s1;
      ack_tgl <= next_ack_tgl;
    end
  end

  jtg_fifo #(
    .WIDTH (DR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (user_hold),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data_out)
  );

endmodule

// ---- testbench/jtg_tap_properties.sv ----
// Concurrent checks on the pins of the test port.
// Assumes it is bound to jtg_tap and sees only its ports.
`timescale 1ns/1ps
module jtg_tap_properties
  import jtg_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic             tck,
  input wire logic             tms,
  input wire logic             tdi,
  input wire logic             tdo,
  input wire logic             tdo_oe,
  input wire logic [BSR_N-1:0] pad_i,
  input wire logic [BSR_N-1:0] pad_o,
  input wire logic [BSR_N-1:0] pad_oe,
  input wire logic [BSR_N-1:0] core_o,
  input wire logic [BSR_N-1:0] core_oe,
  input wire logic             data_valid,
  input wire logic             data_ready,
  input wire logic [DR_W-1:0]  data_out
);
  // ----------
  // Link side
  // ----------
  // Five highs then a low always lands in Idle
  sequence s_tlr;
    tms [*5] ##1 !tms;
  endsequence

  AST_OE_DROP: assert property (@(posedge tck) disable iff (rst) tms |=> !tdo_oe)
    else $error("tdo still driven after leaving shift");
  AST_OE_HOLD: assert property (@(posedge tck) disable iff (rst) tdo_oe && !tms |=> tdo_oe)
    else $error("shift state left with tms low");
  AST_TLR: assert property (@(posedge tck) disable iff (rst) s_tlr ##1 !tms |=> !tdo_oe)
    else $error("no reset after five tms highs");
  AST_DR_ENTRY: assert property (@(posedge tck) disable iff (rst)
    s_tlr ##1 tms ##1 (!tms) [*2] |=> tdo_oe && tdo)
    else $error("identification bit0 not driven on entry");
  AST_IR_ENTRY: assert property (@(posedge tck) disable iff (rst)
    s_tlr ##1 tms [*2] ##1 (!tms) [*2] |=> tdo_oe && tdo == IR_CAPTURE[0])
    else $error("instruction capture bit0 not driven");

  // ----------
  // Core side
  // ----------
  AST_OE_RESET: assert property (@(posedge mclk) disable iff (rst) $past(rst) |-> !tdo_oe)
    else $error("tdo driven right after reset");
  AST_PAD_FOLLOW: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) && pad_oe != '1 |-> pad_o == $past(core_o) && pad_oe == $past(core_oe))
    else $error("pins do not follow the core outside test");
  AST_FIFO_HOLD: assert property (@(posedge mclk) disable iff (rst)
    data_valid && !data_ready |=> data_valid && $stable(data_out))
    else $error("stalled head word changed");

  COV_SHIFT: cover property (@(posedge tck) disable iff (rst) $rose(tdo_oe));
  COV_EXTEST: cover property (@(posedge mclk) disable iff (rst) pad_oe == '1);
  COV_POP: cover property (@(posedge mclk) disable iff (rst) data_valid && data_ready);
endmodule

bind jtg_tap jtg_tap_properties i_props (
  .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
  .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .core_o(core_o), .core_oe(core_oe),
  .data_valid(data_valid), .data_ready(data_ready), .data_out(data_out)
);

// ---- testbench/jtg_tester.sv ----
// Behavioural boundary-scan tester driving tck, tms and tdi and reading tdo.
// Assumes tdo has a pull-up; tck stands still between frames.
`timescale 1ns/1ps
module jtg_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic tdo_line;

  assign tdo_line = (tdo_oe === 1'b1) ? tdo : 1'b1;  // Released line floats high

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 6 ns link cycle; tms and tdi settle while tck is low
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #3;
    q = tdo_line;
    tck = 1'b1;
    #3;
    tck = 1'b0;
  endtask

  task automatic idle(input int n);
    logic q;
    repeat (n) step(1'b0, ~tdi, q);
  endtask

  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask

  // From Idle through one shift of n bits, LSB first, back to Idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule

// ---- testbench/jtg_tap_tb.sv ----
// Self-checking bench for the boundary-scan test port.
// Assumes jtg_tester drives the link; the bench drives core side and pins.
`timescale 1ns/1ps
module jtg_tap_tb
  import jtg_pkg::*;
;
  logic             mclk;
  logic             rst;
  logic             tck;
  logic             tms;
  logic             tdi;
  logic             tdo;
  logic             tdo_oe;
  logic [BSR_N-1:0] pad_i;
  logic [BSR_N-1:0] pad_o;
  logic [BSR_N-1:0] pad_oe;
  logic [BSR_N-1:0] core_o;
  logic [BSR_N-1:0] core_oe;
  logic             data_valid;
  logic             data_ready;
  logic [DR_W-1:0]  data_out;
  int               n_mismatch = 0;
  int               checks_done = 0;

  jtg_tap i_dut (
    .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .core_o(core_o), .core_oe(core_oe),
    .data_valid(data_valid), .data_ready(data_ready), .data_out(data_out)
  );

  jtg_tester i_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------
  // Helpers
  // ----------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for the head word, then one pop
  task automatic pop(input logic [31:0] exp);
    int k;
    k = 0;
    @(negedge mclk);
    while (data_valid !== 1'b1 && k < 50) begin
      @(negedge mclk);
      k++;
    end
    check(data_out, exp);
    @(posedge mclk);
    data_ready <= 1'b1;
    @(posedge mclk);
    data_ready <= 1'b0;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_idcode();
    logic [31:0] v;
    i_tst.reset_tap();
    i_tst.scan(1'b0, 32, 32'h0000_0000, v);
    check(v, ID_WORD);
    check({31'b0, tdo_oe}, 32'h0000_0000);
  endtask

  task automatic t_bypass();
    logic [31:0] v;
    logic [3:0]  op [2] = '{OP_BYPASS, 4'h7};
    foreach (op[i]) begin
      i_tst.scan(1'b1, 4, {28'h0, op[i]}, v);
      check(v, {28'h0, IR_CAPTURE});
      i_tst.scan(1'b0, 2, 32'h0000_0001, v);
      check(v, 32'h0000_0002);
    end
  endtask

  task automatic t_boundary();
    logic [31:0] v;
    @(posedge mclk);
    pad_i <= 8'h5a;
    core_o <= 8'h69;
    i_tst.scan(1'b1, 4, {28'h0, OP_SAMPLE}, v);
    i_tst.scan(1'b0, 8, 32'h0000_00a5, v);
    check(v, 32'h0000_005a);
    check({16'h0, pad_oe, pad_o}, 32'h0000_0f69);
    @(posedge mclk);
    pad_i <= 8'hc3;
    i_tst.scan(1'b1, 4, {28'h0, OP_EXTEST}, v);
    check({16'h0, pad_oe, pad_o}, 32'h0000_ffa5);
    i_tst.scan(1'b0, 8, 32'h0000_003c, v);
    check(v, 32'h0000_00c3);
    check({16'h0, pad_oe, pad_o}, 32'h0000_ff3c);
    i_tst.reset_tap();
    repeat (3) @(posedge mclk);
    check({16'h0, pad_oe, pad_o}, 32'h0000_0f69);
  endtask

  // Fill past depth with the consumer stalled, hit busy, then drain
  task automatic t_stream();
    logic [31:0] v;
    i_tst.scan(1'b1, 4, {28'h0, OP_USER}, v);
    for (int i = 0; i < 17; i++) begin
      i_tst.scan(1'b0, 32, 32'h1000_0000 + i, v);
      check(v, 32'h0000_0000);
      i_tst.idle(12);
    end
    i_tst.scan(1'b0, 32, 32'h0bad_0bad, v);
    check(v, 32'h0000_0001);
    for (int i = 0; i < 17; i++) pop(32'h1000_0000 + i);
    repeat (6) @(negedge mclk);
    check({31'b0, data_valid}, 32'h0000_0000);
  endtask

  initial begin
    rst = 1'b1;
    data_ready = 1'b0;
    pad_i = 8'h00;
    core_o = 8'h96;
    core_oe = 8'h0f;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_idcode();
    t_bypass();
    t_boundary();
    t_stream();
    finish_test();
  end

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule
